// File: src/bth_type1_regs.sv
// Type-one header register bank, cache line size through I/O limit
//
// Contract
// - Odd or over-32-dword cache size means zero
// - Prefetch amount follows programmed cache line size
// - Primary latency timer always reads zero
// - Header type reads 01h, single function
// - Self-test byte always reads zero
// - Control base 31:12 writable only when diag set
// - Control window is 4096 bytes at base
// - Control base low bits read zero
// - Upstream bus number writable, resets to zero
// - Downstream bus number steers type 1 response
// - Highest bus number steers type 1 response
// - Downstream latency timer writable, resets zero
// - I/O bottom bits 15:12, upper half external
// - I/O low nibble reads 1h, 32-bit
// - I/O top byte resets to 01h
// - I/O top bits 15:12, low bits FFFh
`timescale 1ns/1ps
module bth_type1_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Configuration access port, one dword per request
  input  wire logic        cfgWrEn,
  input  wire logic        cfgRdEn,
  input  wire logic [5:0]  cfgDwordIdx,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic             cfgRdValid,
  output logic             cfgRdHit,
  // Neighbouring configuration state
  input  wire logic        diagCtrlWindowWritable,
  input  wire logic [15:0] ioBottomUpper,
  input  wire logic [15:0] ioTopUpper,
  // Forwarding queries
  input  wire logic [31:0] ioQueryAddr,
  input  wire logic [31:0] memQueryAddr,
  input  wire logic [7:0]  cfgQueryBus,
  // Forwarding decisions, one cycle after the query
  output logic             ioForward,
  output logic             ctrlWindowHit,
  output logic             type1ToType0,
  output logic             type1Forward,
  // Programmed state for the datapath
  output logic      [7:0]  prefetchDwords,
  output logic      [7:0]  upstreamBus,
  output logic      [7:0]  downstreamBus,
  output logic      [7:0]  highestBus,
  output logic      [7:0]  downstreamLatency,
  output logic      [31:0] ctrlWindowBase
);

  // Stored fields
  logic [7:0]  cacheLineSize_q;
  logic [7:0]  cacheLineSize_d;
  logic [19:0] ctrlBase_q;
  logic [19:0] ctrlBase_d;
  logic [7:0]  upstreamBus_q;
  logic [7:0]  upstreamBus_d;
  logic [7:0]  downstreamBus_q;
  logic [7:0]  downstreamBus_d;
  logic [7:0]  highestBus_q;
  logic [7:0]  highestBus_d;
  logic [7:0]  downLatency_q;
  logic [7:0]  downLatency_d;
  logic [3:0]  ioBottom_q;
  logic [3:0]  ioBottom_d;
  logic [3:0]  ioTop_q;
  logic [3:0]  ioTop_d;

  // Read return
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic        rdValid_q;
  logic        rdHit_q;
  logic        rdHit_d;

  // Address decode
  logic        selCache;
  logic        selCtrl;
  logic        selBus;
  logic        selIo;
  logic        wrCache;
  logic        wrCtrl;
  logic        wrBus;
  logic        wrIo;

  // Read words as software sees them
  logic [31:0] wordCache;
  logic [31:0] wordCtrl;
  logic [31:0] wordBus;
  logic [31:0] wordIo;

  // Write merge helpers
  logic [31:0] laneMask;
  logic [31:0] ctrlFull;
  logic [31:0] ctrlMerged;
  logic        ctrlUnlocked;

  // Derived values
  logic        cacheOdd;
  logic        cacheTooBig;
  logic [31:0] ioBottomAddr;
  logic [31:0] ioTopAddr;
  logic [7:0]  prefetch_q;
  logic [7:0]  prefetch_d;

  // Carrier to the window decoder
  bth_window_if win ();

  // Decode of the dword being accessed
  assign selCache = (cfgDwordIdx == bth_pkg::DW_CACHE);
  assign selCtrl  = (cfgDwordIdx == bth_pkg::DW_CTRL);
  assign selBus   = (cfgDwordIdx == bth_pkg::DW_BUS);
  assign selIo    = (cfgDwordIdx == bth_pkg::DW_IO);
  assign wrCache  = cfgWrEn && selCache;
  assign wrCtrl   = cfgWrEn && selCtrl;
  assign wrBus    = cfgWrEn && selBus;
  assign wrIo     = cfgWrEn && selIo;

  // Byte enables expanded to bit lanes
  assign laneMask = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}}, {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

  // Cache line dword: only byte 0 holds state, the others are constants
  assign wordCache = {bth_pkg::VAL_SELF_TEST,
                      bth_pkg::VAL_HEADER_TYPE,
                      bth_pkg::VAL_PRIMARY_LATENCY,
                      cacheLineSize_q};

  // Control base dword: low 12 bits are hard zero
  assign wordCtrl = {ctrlBase_q, bth_pkg::CTRL_LOW_BITS};

  // Bus number dword: four independent bytes
  assign wordBus = {downLatency_q, highestBus_q, downstreamBus_q, upstreamBus_q};

  // I/O dword: bytes 2 and 3 belong to another block and read zero here
  assign wordIo = {bth_pkg::BYTE_ZERO,
                   bth_pkg::BYTE_ZERO,
                   ioTop_q, bth_pkg::IO_ADDRESSING_CODE,
                   ioBottom_q, bth_pkg::IO_ADDRESSING_CODE};

  // Read mux; unclaimed dwords read zero and report no hit
  assign rdData_d = selCache ? wordCache :
                    selCtrl  ? wordCtrl  :
                    selBus   ? wordBus   :
                    selIo    ? wordIo    : 32'h00000000;
  assign rdHit_d  = selCache || selCtrl || selBus || selIo;

  // Cache line size: stored as written, qualified on use
  assign cacheLineSize_d = (wrCache && cfgByteEn[0]) ? cfgWrData[7:0] : cacheLineSize_q;

  // Base bits open only while the diagnostic bit is set; otherwise writes fall away
  assign ctrlUnlocked = diagCtrlWindowWritable;
  assign ctrlFull     = {ctrlBase_q, bth_pkg::CTRL_LOW_BITS};
  assign ctrlMerged   = (cfgWrData & laneMask) | (ctrlFull & ~laneMask);
  assign ctrlBase_d   = (wrCtrl && ctrlUnlocked) ? ctrlMerged[31:bth_pkg::CTRL_ADDR_LSB] : ctrlBase_q;

  // Bus numbers and latency timer, byte-lane writes
  assign upstreamBus_d   = (wrBus && cfgByteEn[0]) ? cfgWrData[7:0]   : upstreamBus_q;
  assign downstreamBus_d = (wrBus && cfgByteEn[1]) ? cfgWrData[15:8]  : downstreamBus_q;
  assign highestBus_d    = (wrBus && cfgByteEn[2]) ? cfgWrData[23:16] : highestBus_q;
  assign downLatency_d   = (wrBus && cfgByteEn[3]) ? cfgWrData[31:24] : downLatency_q;

  // I/O window nibbles; the type code nibbles take no write
  assign ioBottom_d = (wrIo && cfgByteEn[0]) ? cfgWrData[7:4]   : ioBottom_q;
  assign ioTop_d    = (wrIo && cfgByteEn[1]) ? cfgWrData[15:12] : ioTop_q;

  // Cache line size; kept as written so software reads back its own value
  always_ff @(posedge clk)
  begin
    if (srst)
      cacheLineSize_q <= bth_pkg::RST_CACHE_LINE_SIZE;
    else
      cacheLineSize_q <= cacheLineSize_d;
  end

  // Prefetch length registered beside the size, so both change on the same edge
  always_ff @(posedge clk)
  begin
    if (srst)
      prefetch_q <= bth_pkg::CACHE_INVALID_DWORDS;
    else
      prefetch_q <= prefetch_d;
  end

  // Control window base; locked writes simply keep the old value
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrlBase_q <= bth_pkg::RST_CTRL_BASE;
    else
      ctrlBase_q <= ctrlBase_d;
  end

  // Bus numbers and downstream latency timer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      upstreamBus_q   <= bth_pkg::RST_BUS_NUMBER;
      downstreamBus_q <= bth_pkg::RST_BUS_NUMBER;
      highestBus_q    <= bth_pkg::RST_BUS_NUMBER;
      downLatency_q   <= bth_pkg::RST_LATENCY;
    end
    else
    begin
      upstreamBus_q   <= upstreamBus_d;
      downstreamBus_q <= downstreamBus_d;
      highestBus_q    <= highestBus_d;
      downLatency_q   <= downLatency_d;
    end
  end

  // I/O window nibbles; the fixed type code nibbles have no flops, so writes to them vanish
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ioBottom_q <= bth_pkg::RST_IO_WINDOW_NIBBLE;
      ioTop_q    <= bth_pkg::RST_IO_WINDOW_NIBBLE;
    end
    else
    begin
      ioBottom_q <= ioBottom_d;
      ioTop_q    <= ioTop_d;
    end
  end

  // Read data and hit flag, loaded only when a read is taken and held until the next one
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdData_q <= 32'h00000000;
      rdHit_q  <= 1'h0;
    end
    else
    begin
      rdData_q <= cfgRdEn ? rdData_d : rdData_q;
      rdHit_q  <= cfgRdEn ? rdHit_d : rdHit_q;
    end
  end

  // Read valid pulses one edge after the request; a same-cycle write is seen by the next read
  always_ff @(posedge clk)
  begin
    if (srst)
      rdValid_q <= 1'h0;
    else
      rdValid_q <= cfgRdEn;
  end

  // Illegal sizes fall back to zero; software should only write powers of two
  // Qualified from the next value so the prefetch length moves on the same edge as the size
  assign cacheOdd    = cacheLineSize_d[0];
  assign cacheTooBig = (cacheLineSize_d > bth_pkg::CACHE_MAX_DWORDS);

  // Prefetch length for delayed reads, in dwords
  assign prefetch_d = (cacheOdd || cacheTooBig) ? bth_pkg::CACHE_INVALID_DWORDS : cacheLineSize_d;

  // I/O window bounds: bottom pads with zeros, top pads with ones
  assign ioBottomAddr = {ioBottomUpper, ioBottom_q, bth_pkg::IO_BOTTOM_FILL};
  assign ioTopAddr    = {ioTopUpper, ioTop_q, bth_pkg::IO_TOP_FILL};

  // Hand bounds and queries to the decoder
  assign win.ioBottom = ioBottomAddr;
  assign win.ioTop    = ioTopAddr;
  assign win.ctrlBase = ctrlBase_q;
  assign win.downBus  = downstreamBus_q;
  assign win.highBus  = highestBus_q;
  assign win.ioAddr   = ioQueryAddr;
  assign win.memAddr  = memQueryAddr;
  assign win.busNum   = cfgQueryBus;

  // Window decoder; its decisions lag the queries by one edge
  bth_window_decode bth_window_decode_inst (
    .clk  (clk),
    .srst (srst),
    .win  (win.dec)
  );

  // Outputs
  assign cfgRdData         = rdData_q;
  assign cfgRdValid        = rdValid_q;
  assign cfgRdHit          = rdHit_q;
  assign prefetchDwords    = prefetch_q;
  assign ioForward         = win.ioFwd;
  assign ctrlWindowHit     = win.ctrlHit;
  assign type1ToType0      = win.toType0;
  assign type1Forward      = win.fwdType1;
  assign upstreamBus       = upstreamBus_q;
  assign downstreamBus     = downstreamBus_q;
  assign highestBus        = highestBus_q;
  assign downstreamLatency = downLatency_q;
  assign ctrlWindowBase    = wordCtrl;

endmodule

// File: src/bth_pkg.sv
// Constants shared by the bridge type-one header register bank and its window decoder
package bth_pkg;

  // Byte offsets of the registers in configuration space
  localparam logic [7:0] OFF_CACHE_LINE_SIZE       = 8'h0C;
  localparam logic [7:0] OFF_PRIMARY_LATENCY_TIMER = 8'h0D;
  localparam logic [7:0] OFF_HEADER_TYPE           = 8'h0E;
  localparam logic [7:0] OFF_SELF_TEST             = 8'h0F;
  localparam logic [7:0] OFF_CONTROL_WINDOW_BASE   = 8'h10;
  localparam logic [7:0] OFF_UPSTREAM_BUS_NUMBER   = 8'h18;
  localparam logic [7:0] OFF_DOWNSTREAM_BUS_NUMBER = 8'h19;
  localparam logic [7:0] OFF_HIGHEST_BUS_NUMBER    = 8'h1A;
  localparam logic [7:0] OFF_DOWNSTREAM_LATENCY    = 8'h1B;
  localparam logic [7:0] OFF_IO_WINDOW_LOW         = 8'h1C;
  localparam logic [7:0] OFF_IO_WINDOW_HIGH        = 8'h1D;

  // Dword numbers used on the configuration port
  localparam logic [5:0] DW_CACHE   = OFF_CACHE_LINE_SIZE[7:2];
  localparam logic [5:0] DW_CTRL    = OFF_CONTROL_WINDOW_BASE[7:2];
  localparam logic [5:0] DW_BUS     = OFF_UPSTREAM_BUS_NUMBER[7:2];
  localparam logic [5:0] DW_IO      = OFF_IO_WINDOW_LOW[7:2];

  // Reset and fixed values
  localparam logic [7:0]  RST_CACHE_LINE_SIZE   = 8'h00;
  localparam logic [7:0]  VAL_PRIMARY_LATENCY   = 8'h00;
  localparam logic [7:0]  VAL_HEADER_TYPE       = 8'h01;
  localparam logic [7:0]  VAL_SELF_TEST         = 8'h00;
  localparam logic [19:0] RST_CTRL_BASE         = 20'h00000;
  localparam logic [7:0]  RST_BUS_NUMBER        = 8'h00;
  localparam logic [7:0]  RST_LATENCY           = 8'h00;
  localparam logic [3:0]  RST_IO_WINDOW_NIBBLE  = 4'h0;
  localparam logic [3:0]  IO_ADDRESSING_CODE    = 4'h1;

  // Cache line size qualification
  localparam logic [7:0]  CACHE_MAX_DWORDS      = 8'h20;
  localparam logic [7:0]  CACHE_INVALID_DWORDS  = 8'h00;

  // Control window base: 20 address bits above a 4096-byte window
  localparam int          CTRL_ADDR_LSB         = 12;
  localparam logic [11:0] CTRL_LOW_BITS         = 12'h000;

  // I/O window assembly
  localparam logic [11:0] IO_BOTTOM_FILL        = 12'h000;
  localparam logic [11:0] IO_TOP_FILL           = 12'hFFF;

  // Filler for bytes with no state in this bank
  localparam logic [7:0]  BYTE_ZERO             = 8'h00;

endpackage

// File: src/bth_window_if.sv
// Carrier between the register bank and the window decoder
`timescale 1ns/1ps
interface bth_window_if;
  logic [31:0] ioBottom;
  logic [31:0] ioTop;
  logic [19:0] ctrlBase;
  logic [7:0]  downBus;
  logic [7:0]  highBus;
  logic [31:0] ioAddr;
  logic [31:0] memAddr;
  logic [7:0]  busNum;
  logic        ioFwd;
  logic        ctrlHit;
  logic        toType0;
  logic        fwdType1;

  modport regs (
    output ioBottom, ioTop, ctrlBase, downBus, highBus, ioAddr, memAddr, busNum,
    input  ioFwd, ctrlHit, toType0, fwdType1
  );
  modport dec (
    input  ioBottom, ioTop, ctrlBase, downBus, highBus, ioAddr, memAddr, busNum,
    output ioFwd, ctrlHit, toType0, fwdType1
  );
endinterface

// File: src/bth_window_decode.sv
// Address window and bus number decoder for forwarding decisions
`timescale 1ns/1ps
module bth_window_decode (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // Windows, queries and decisions
  bth_window_if.dec  win
);

  logic ioFwd_d;
  logic ctrlHit_d;
  logic toType0_d;
  logic fwdType1_d;
  logic ioFwd_q;
  logic ctrlHit_q;
  logic toType0_q;
  logic fwdType1_q;

  // Both I/O bounds inclusive
  assign ioFwd_d    = (win.ioAddr >= win.ioBottom) && (win.ioAddr <= win.ioTop);
  // Window is the 4096 bytes under the 20 base bits
  assign ctrlHit_d  = (win.memAddr[31:bth_pkg::CTRL_ADDR_LSB] == win.ctrlBase);
  // Bus equal to downstream bus is converted, buses behind it pass as type 1
  assign toType0_d  = (win.busNum == win.downBus);
  assign fwdType1_d = (win.busNum > win.downBus) && (win.busNum <= win.highBus);

  // Decisions registered, one cycle after the query
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ioFwd_q    <= 1'h0;
      ctrlHit_q  <= 1'h0;
      toType0_q  <= 1'h0;
      fwdType1_q <= 1'h0;
    end
    else
    begin
      ioFwd_q    <= ioFwd_d;
      ctrlHit_q  <= ctrlHit_d;
      toType0_q  <= toType0_d;
      fwdType1_q <= fwdType1_d;
    end
  end

  assign win.ioFwd    = ioFwd_q;
  assign win.ctrlHit  = ctrlHit_q;
  assign win.toType0  = toType0_q;
  assign win.fwdType1 = fwdType1_q;

endmodule

// File: testbench/bth_type1_regs_assertions.sv
// Concurrent checks on the type-one header register bank ports
`timescale 1ns/1ps
module bth_type1_regs_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Configuration port
  input wire logic        cfgWrEn,
  input wire logic [5:0]  cfgDwordIdx,
  input wire logic [3:0]  cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic        cfgRdValid,
  input wire logic        diagCtrlWindowWritable,
  // Queries, decisions and programmed state
  input wire logic [31:0] memQueryAddr,
  input wire logic [7:0]  cfgQueryBus,
  input wire logic        ctrlWindowHit,
  input wire logic        type1ToType0,
  input wire logic        type1Forward,
  input wire logic [7:0]  prefetchDwords,
  input wire logic [7:0]  upstreamBus,
  input wire logic [7:0]  downstreamBus,
  input wire logic [7:0]  highestBus,
  input wire logic [7:0]  downstreamLatency,
  input wire logic [31:0] ctrlWindowBase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Write strobes per dword
  wire wrCache = cfgWrEn && cfgDwordIdx == 6'h03 && cfgByteEn[0];
  wire wrCtrl  = cfgWrEn && cfgDwordIdx == 6'h04;
  wire wrBus   = cfgWrEn && cfgDwordIdx == 6'h06 && cfgByteEn == 4'hF;
  a_fixed_header: assert property (cfgRdValid && $past(cfgDwordIdx) == 6'h03 |->
    cfgRdData[31:8] == 24'h000100) else $error("fixed header bytes wrong");
  a_io_type_code: assert property (cfgRdValid && $past(cfgDwordIdx) == 6'h07 |->
    cfgRdData[3:0] == 4'h1 && cfgRdData[11:8] == 4'h1) else $error("io width code wrong");
  a_ctrl_low_zero: assert property (ctrlWindowBase[11:0] == 12'h000)
    else $error("control base low bits nonzero");
  a_base_locked: assert property (wrCtrl && !diagCtrlWindowWritable |=> $stable(ctrlWindowBase))
    else $error("locked control base changed");
  a_base_open: assert property (wrCtrl && diagCtrlWindowWritable && cfgByteEn == 4'hF |=>
    ctrlWindowBase[31:12] == $past(cfgWrData[31:12])) else $error("control base not written");
  a_prefetch_rule: assert property (wrCache |=> prefetchDwords ==
    (($past(cfgWrData[0]) || $past(cfgWrData[7:0]) > 8'h20) ? 8'h00 : $past(cfgWrData[7:0])))
    else $error("prefetch size wrong");
  a_bus_write: assert property (wrBus |=> upstreamBus == $past(cfgWrData[7:0]) &&
    downstreamLatency == $past(cfgWrData[31:24])) else $error("bus byte write lost");
  a_ctrl_hit: assert property (!$past(srst) |-> ctrlWindowHit ==
    ($past(memQueryAddr[31:12]) == $past(ctrlWindowBase[31:12]))) else $error("control hit wrong");
  a_type0_route: assert property (!$past(srst) |-> type1ToType0 ==
    ($past(cfgQueryBus) == $past(downstreamBus))) else $error("type0 routing wrong");
  a_type1_fwd: assert property (!$past(srst) |-> type1Forward == ($past(cfgQueryBus) >
    $past(downstreamBus) && $past(cfgQueryBus) <= $past(highestBus))) else $error("type1 forward wrong");
endmodule

// File: testbench/bth_cfg_host_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module bth_cfg_host_model (
  // Clock
  input  wire logic        clk,
  // Request lines
  output logic             cfgWrEn,
  output logic             cfgRdEn,
  output logic [5:0]       cfgDwordIdx,
  output logic [3:0]       cfgByteEn,
  output logic [31:0]      cfgWrData,
  // Answer
  input  wire logic [31:0] cfgRdData,
  input  wire logic        cfgRdValid,
  input  wire logic        cfgRdHit
);
  // Idle at time zero
  initial
  begin
    cfgWrEn = 1'b0;
    cfgRdEn = 1'b0;
    cfgDwordIdx = 6'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0;
  end
  // Held through the taking edge; released lines inverted so stale values never look valid
  task automatic cfgWrite(input logic [5:0] i, input logic [3:0] b, input logic [31:0] v);
    cfgDwordIdx = i;
    cfgByteEn = b;
    cfgWrData = v;
    cfgWrEn = 1'b1;
    @(posedge clk);
    #1;
    cfgWrEn = 1'b0;
    cfgByteEn = ~b;
    cfgWrData = ~v;
    @(posedge clk);
    #1;
  endtask
  // Answer is registered, so it is settled just after the taking edge
  task automatic cfgRead(input logic [5:0] i, output logic [31:0] d, output logic h, output logic v);
    cfgDwordIdx = i;
    cfgRdEn = 1'b1;
    @(posedge clk);
    #1;
    cfgRdEn = 1'b0;
    cfgDwordIdx = ~i;
    d = cfgRdData;
    h = cfgRdHit;
    v = cfgRdValid;
    @(posedge clk);
    #1;
  endtask
endmodule

// File: testbench/bth_type1_regs_bench.sv
// Self-checking bench for the type-one header register bank
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module bth_type1_regs_bench;
  logic        clk = 1'b0, srst = 1'b1, diag = 1'b0;
  logic        cfgWrEn, cfgRdEn, cfgRdValid, cfgRdHit, ioFwd, ctrlHit, toT0, t1Fwd, hit, vld;
  logic [5:0]  cfgDwordIdx, idx;
  logic [3:0]  cfgByteEn, iob = 4'h0, iot = 4'h0;
  logic [31:0] cfgWrData, cfgRdData, ctrlBase, r, lo, hi, ioQ = 32'h0, memQ = 32'h0;
  logic [15:0] ioLoUp = 16'h0000, ioHiUp = 16'h0000;
  logic [7:0]  qBus = 8'h00, prefetch, upB, downB, highB, lat;
  logic [7:0]  cl = 8'h00, up = 8'h00, dn = 8'h00, hb = 8'h00, lt = 8'h00;
  logic [19:0] base = 20'h00000;
  logic [5:0]  idxList [8] = '{6'h03, 6'h04, 6'h06, 6'h07, 6'h00, 6'h05, 6'h08, 6'h3F};
  logic [7:0]  clList [6] = '{8'h20, 8'h21, 8'h40, 8'h03, 8'h10, 8'h01};
  int          failures = 0, totalChecks = 0, cycles = 0, seed = 93;

  always #10 clk = ~clk;

  bth_type1_regs bth_type1_regs_inst (.clk(clk), .srst(srst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgDwordIdx(cfgDwordIdx), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .cfgRdHit(cfgRdHit), .diagCtrlWindowWritable(diag), .ioBottomUpper(ioLoUp),
    .ioTopUpper(ioHiUp), .ioQueryAddr(ioQ), .memQueryAddr(memQ), .cfgQueryBus(qBus), .ioForward(ioFwd),
    .ctrlWindowHit(ctrlHit), .type1ToType0(toT0), .type1Forward(t1Fwd), .prefetchDwords(prefetch),
    .upstreamBus(upB), .downstreamBus(downB), .highestBus(highB), .downstreamLatency(lat),
    .ctrlWindowBase(ctrlBase));
  bth_cfg_host_model bth_cfg_host_model_inst (.clk(clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgDwordIdx(cfgDwordIdx), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .cfgRdHit(cfgRdHit));

  // Expected read image of each dword
  function automatic logic [31:0] expRead(input logic [5:0] i);
    case (i)
      6'h03: expRead = {16'h0001, 8'h00, cl};
      6'h04: expRead = {base, 12'h000};
      6'h06: expRead = {lt, hb, dn, up};
      6'h07: expRead = {16'h0000, iot, 4'h1, iob, 4'h1};
      default: expRead = 32'h0;
    endcase
  endfunction

  // Write through the host and mirror only the writable fields
  task automatic doWrite(input logic [5:0] i, input logic [3:0] b, input logic [31:0] v);
    bth_cfg_host_model_inst.cfgWrite(i, b, v);
    if (i == 6'h03 && b[0]) cl = v[7:0];
    if (i == 6'h04 && diag)
    begin
      if (b[1]) base[3:0] = v[15:12];
      if (b[2]) base[11:4] = v[23:16];
      if (b[3]) base[19:12] = v[31:24];
    end
    if (i == 6'h06)
    begin
      if (b[0]) up = v[7:0];
      if (b[1]) dn = v[15:8];
      if (b[2]) hb = v[23:16];
      if (b[3]) lt = v[31:24];
    end
    if (i == 6'h07 && b[0]) iob = v[7:4];
    if (i == 6'h07 && b[1]) iot = v[15:12];
  endtask

  // Read back one dword, check valid and hit, and compare the prefetch, bus number and control base outputs
  task automatic checkAll(input logic [5:0] i);
    bth_cfg_host_model_inst.cfgRead(i, r, hit, vld);
    `CHK(vld, 1'b1)
    `CHK(r, expRead(i))
    `CHK(hit, i inside {6'h03, 6'h04, 6'h06, 6'h07})
    `CHK(prefetch, (cl[0] || cl > 8'h20) ? 8'h00 : cl)
    `CHK({upB, downB, highB, lat}, {up, dn, hb, lt})
    `CHK(ctrlBase, {base, 12'h000})
  endtask

  // Drive one query set; decisions land one cycle later
  task automatic query(input logic [31:0] a);
    logic [31:0] x;
    x = $random(seed);
    ioQ = a;
    memQ = x[2] ? {base, x[11:0]} : x;
    qBus = x[4] ? (x[3] ? hb : dn) : x[31:24];
    @(posedge clk);
    #1;
    `CHK(ioFwd, a >= lo && a <= hi)
    `CHK(ctrlHit, memQ[31:12] == base)
    `CHK(toT0, qBus == dn)
    `CHK(t1Fwd, qBus > dn && qBus <= hb)
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset values, corner writes, then random traffic with window queries
  initial
  begin
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    @(posedge clk);
    #1;
    foreach (idxList[n]) checkAll(idxList[n]);
    // Legal powers of two mixed with odd and oversized values
    foreach (clList[n])
    begin
      doWrite(6'h03, 4'hF, {24'hFFFFFF, clList[n]});
      checkAll(6'h03);
    end
    diag = 1'b1;
    doWrite(6'h04, 4'hF, 32'hABCDEFFF);
    checkAll(6'h04);
    diag = 1'b0;
    doWrite(6'h04, 4'hF, 32'h12345678);
    checkAll(6'h04);
    doWrite(6'h06, 4'hF, 32'h40302010);
    doWrite(6'h07, 4'hF, 32'hFFFFFFFF);
    checkAll(6'h07);
    repeat (60)
    begin
      diag = 1'($random(seed));
      idx = idxList[$unsigned($random(seed)) % 8];
      ioLoUp = 16'($random(seed));
      ioHiUp = 16'($random(seed));
      doWrite(idx, 4'($random(seed)), $random(seed));
      checkAll(idx);
      lo = {ioLoUp, iob, 12'h000};
      hi = {ioHiUp, iot, 12'hFFF};
      query(lo);
      query(lo - 32'h1);
      query(hi);
      query(hi + 32'h1);
      query($random(seed));
    end
    // Mid-run reset must bring every stored field back to its reset value
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    {cl, up, dn, hb, lt} = 40'h0;
    {iob, iot, base} = 28'h0;
    @(posedge clk);
    #1;
    foreach (idxList[n]) checkAll(idxList[n]);
    test_done();
  end
endmodule

bind bth_type1_regs bth_type1_regs_assertions bth_type1_regs_assertions_inst (.clk, .srst, .cfgWrEn,
  .cfgDwordIdx, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .diagCtrlWindowWritable, .memQueryAddr,
  .cfgQueryBus, .ctrlWindowHit, .type1ToType0, .type1Forward, .prefetchDwords, .upstreamBus,
  .downstreamBus, .highestBus, .downstreamLatency, .ctrlWindowBase);
